/* File: verilog/iqrm_pkg.sv */
// constants and types shared by the receive mode control block
package iqrm_pkg;

  // ****************************************************************
  // serial load word layout
  // ****************************************************************
  localparam int LOAD_WORD_BITS = 16;
  localparam int LOAD_ADDR_LSB = 12;
  localparam int LOAD_DATA_BITS = 10;
  localparam logic [4:0] LOAD_LAST_BIT = 5'h0f;

  // register addresses carried in the top nibble of a load word
  localparam logic [3:0] ADDR_RESET = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_I_OFFSET = 4'h5;
  localparam logic [3:0] ADDR_Q_OFFSET = 4'h6;

  // ****************************************************************
  // receive_mode_control field positions and reset values
  // ****************************************************************
  localparam int CMD_WIDTH = 10;
  localparam int SAMPLE_RATE_SEL_BIT = 0;
  localparam int FILTER_RESPONSE_SEL_BIT = 1;
  localparam int INPUT_PAIR_SEL_BIT = 2;
  localparam int CALIBRATION_MODE_SEL_BIT = 3;
  localparam int RECEIVE_POWER_ON_BIT = 4;
  localparam int AUX_DAC_THREE_POWER_ON_BIT = 5;
  localparam int AUX_DAC_TWO_POWER_ON_BIT = 6;
  localparam int AUX_DAC_ONE_POWER_ON_BIT = 7;
  localparam int SERIAL_OUT_TRISTATE_BIT = 8;
  localparam int SPARE_BIT = 9;
  localparam logic [9:0] CMD_RESET = 10'h000;
  localparam logic [9:0] CMD_WRITE_MASK = 10'h1ff;

  // ****************************************************************
  // sample path widths and offset reset value
  // ****************************************************************
  localparam int SAMPLE_BITS = 15;
  localparam int OFFSET_BITS = 10;
  localparam int CAL_SUM_BITS = 19;
  localparam logic [9:0] OFFSET_RESET = 10'h000;

  // ****************************************************************
  // cycle counts against the master clock
  // ****************************************************************
  localparam int FILTER_DIV = 8;
  localparam int SLOW_DIV = 128;
  localparam int FAST_DIV = 64;
  localparam logic [2:0] FILTER_LAST = 3'(FILTER_DIV - 1);
  localparam logic [6:0] SLOW_LAST = 7'(SLOW_DIV - 1);
  localparam logic [6:0] FAST_LAST = 7'(FAST_DIV - 1);
  localparam int CAL_AVG_COUNT = 16;
  localparam logic [3:0] CAL_LAST = 4'(CAL_AVG_COUNT - 1);
  localparam int PAIR_BITS = 32;
  localparam logic [4:0] PAIR_LAST_BIT = 5'(PAIR_BITS - 1);
  localparam logic [4:0] Q_FIRST_BIT = 5'h10;

  // analog-mode filter design point, kept for reference by users of the block
  localparam real ANALOG_MCLK_MHZ = 5.12;
  localparam real ANALOG_RATE_STEP_KHZ = 10.0;
  localparam real ANALOG_CORNER_KHZ = 11.4;

  // receive path power and calibration states
  typedef enum logic [1:0] {
    IQRM_SLEEP,
    IQRM_CAL,
    IQRM_RUN
  } iqrm_state_t;

endpackage : iqrm_pkg

/* File: verilog/iqrm_load_rx.sv */
// serial load port: collects 16-bit command words from the controller
`timescale 1ns/1ps
module iqrm_load_rx (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic load_clk_in,
  input wire logic load_sel_in,
  input wire logic load_data_in,
  output logic word_valid_out,
  output logic [15:0] word_out
);

  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic sel_s1_q, sel_s2_q;
  logic dat_s1_q, dat_s2_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic load_edge;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // only the second stages are looked at; the third clock stage feeds the edge detector
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= load_clk_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      sel_s1_q <= load_sel_in;
      sel_s2_q <= sel_s1_q;
      dat_s1_q <= load_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign load_edge = clk_s2_q && !clk_s3_q;

  // ****************************************************************
  // word assembly, msb first
  // ****************************************************************
  // dropping select mid-word discards the partial word, so a glitch cannot load junk
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      word_valid_out <= 1'b0;
      word_out <= 16'h0000;
    end else begin
      word_valid_out <= 1'b0;
      if (!sel_s2_q) begin
        bit_cnt_q <= 5'h00;
      end else if (load_edge) begin
        shift_q <= {shift_q[14:0], dat_s2_q};
        if (bit_cnt_q == iqrm_pkg::LOAD_LAST_BIT) begin
          bit_cnt_q <= 5'h00;
          word_valid_out <= 1'b1;
          word_out <= {shift_q[14:0], dat_s2_q};
        end else begin
          bit_cnt_q <= 5'(bit_cnt_q + 5'h01);
        end
      end
    end
  end

endmodule : iqrm_load_rx

/* File: verilog/iqrm_mode_ctrl.sv */
// receive mode control: command register, rate timing, calibration, sleep and iq word output
`timescale 1ns/1ps
module iqrm_mode_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic load_clk_in,
  input wire logic load_sel_in,
  input wire logic load_data_in,
  input wire logic [14:0] adc_i_word_in,
  input wire logic [14:0] adc_q_word_in,
  output logic filter_tick_out,
  output logic fir_response_sel_out,
  output logic input_pair_sel_out,
  output logic input_short_out,
  output logic adc_power_on_out,
  output logic narrow_trim_dac_b_power_out,
  output logic narrow_trim_dac_a_power_out,
  output logic wide_trim_dac_power_out,
  output logic rx_clk_out,
  output logic rx_frame_out,
  output logic rx_data_out,
  output logic rx_oe_out,
  output logic [9:0] i_offset_out,
  output logic [9:0] q_offset_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // offset word lands in the low bits of the sample, sign-extended
  function automatic logic [14:0] apply_offset(input logic [14:0] w, input logic [9:0] o);
    logic [14:0] ext;
    ext = {{5{o[9]}}, o};
    return 15'(w - ext);
  endfunction : apply_offset

  function automatic logic [18:0] widen(input logic [14:0] w);
    return {{4{w[14]}}, w};
  endfunction : widen

  function automatic logic [6:0] rate_last(input logic fast);
    return fast ? iqrm_pkg::FAST_LAST : iqrm_pkg::SLOW_LAST;
  endfunction : rate_last

  logic word_valid;
  logic [15:0] word;
  logic [3:0] word_addr;
  logic [9:0] word_data;
  logic [9:0] cmd_q;
  iqrm_pkg::iqrm_state_t state_q;
  logic [2:0] filt_cnt_q;
  logic [6:0] rate_cnt_q;
  logic sample_tick;
  logic [3:0] cal_cnt_q;
  logic [18:0] sum_i_q, sum_q_q;
  logic [18:0] tot_i, tot_q;
  logic cal_done;
  logic [9:0] off_i_q, off_q_q;
  logic [31:0] pair_word;
  logic [31:0] shift_q;
  logic [4:0] bit_idx_q;
  logic phase_q;
  logic busy_q;
  logic start_pair;
  logic power_bit;

  assign power_bit = cmd_q[iqrm_pkg::RECEIVE_POWER_ON_BIT];

  // ****************************************************************
  // serial load port
  // ****************************************************************
  iqrm_load_rx u_load (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .load_clk_in(load_clk_in),
    .load_sel_in(load_sel_in),
    .load_data_in(load_data_in),
    .word_valid_out(word_valid),
    .word_out(word)
  );

  assign word_addr = word[iqrm_pkg::LOAD_WORD_BITS-1:iqrm_pkg::LOAD_ADDR_LSB];
  assign word_data = word[iqrm_pkg::LOAD_DATA_BITS-1:0];

  // ****************************************************************
  // command register
  // ****************************************************************
  // written only when a whole word has arrived, spare bit forced clear
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmd_q <= iqrm_pkg::CMD_RESET;
    end else if (word_valid && word_addr == iqrm_pkg::ADDR_RESET) begin
      cmd_q <= iqrm_pkg::CMD_RESET;
    end else if (word_valid && word_addr == iqrm_pkg::ADDR_COMMAND) begin
      cmd_q <= word_data & iqrm_pkg::CMD_WRITE_MASK;
    end
  end

  // mode pins follow the register one clock later
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fir_response_sel_out <= 1'b0;
      input_pair_sel_out <= 1'b0;
      narrow_trim_dac_b_power_out <= 1'b0;
      narrow_trim_dac_a_power_out <= 1'b0;
      wide_trim_dac_power_out <= 1'b0;
      rx_oe_out <= 1'b0;
    end else begin
      // coefficient bank is chosen outside; the analog bank assumes a 5.12 MHz master clock
      fir_response_sel_out <= cmd_q[iqrm_pkg::FILTER_RESPONSE_SEL_BIT];
      input_pair_sel_out <= cmd_q[iqrm_pkg::INPUT_PAIR_SEL_BIT];
      narrow_trim_dac_b_power_out <= cmd_q[iqrm_pkg::AUX_DAC_THREE_POWER_ON_BIT];
      narrow_trim_dac_a_power_out <= cmd_q[iqrm_pkg::AUX_DAC_TWO_POWER_ON_BIT];
      wide_trim_dac_power_out <= cmd_q[iqrm_pkg::AUX_DAC_ONE_POWER_ON_BIT];
      rx_oe_out <= !cmd_q[iqrm_pkg::SERIAL_OUT_TRISTATE_BIT];
    end
  end

  // ****************************************************************
  // decimation filter tick
  // ****************************************************************
  // free running so the filter keeps its phase across sleep
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      filt_cnt_q <= 3'h0;
      filter_tick_out <= 1'b0;
    end else begin
      filt_cnt_q <= (filt_cnt_q == iqrm_pkg::FILTER_LAST) ? 3'h0 : 3'(filt_cnt_q + 3'h1);
      filter_tick_out <= (filt_cnt_q == iqrm_pkg::FILTER_LAST);
    end
  end

  // ****************************************************************
  // output sample rate
  // ****************************************************************
  // >= rather than == so a switch to the fast rate mid-period cannot overrun
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rate_cnt_q <= 7'h00;
    end else if (state_q == iqrm_pkg::IQRM_SLEEP) begin
      rate_cnt_q <= 7'h00;
    end else if (rate_cnt_q >= rate_last(cmd_q[iqrm_pkg::SAMPLE_RATE_SEL_BIT])) begin
      rate_cnt_q <= 7'h00;
    end else begin
      rate_cnt_q <= 7'(rate_cnt_q + 7'h01);
    end
  end

  assign sample_tick = (state_q != iqrm_pkg::IQRM_SLEEP) &&
                       (rate_cnt_q >= rate_last(cmd_q[iqrm_pkg::SAMPLE_RATE_SEL_BIT]));

  // ****************************************************************
  // power and calibration sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q <= iqrm_pkg::IQRM_SLEEP;
    end else begin
      case (state_q)
        iqrm_pkg::IQRM_SLEEP: begin
          if (power_bit) begin
            if (cmd_q[iqrm_pkg::CALIBRATION_MODE_SEL_BIT]) begin
              state_q <= iqrm_pkg::IQRM_RUN;
            end else begin
              state_q <= iqrm_pkg::IQRM_CAL;
            end
          end
        end
        iqrm_pkg::IQRM_CAL: begin
          if (!power_bit) begin
            state_q <= iqrm_pkg::IQRM_SLEEP;
          end else if (cal_done) begin
            state_q <= iqrm_pkg::IQRM_RUN;
          end
        end
        iqrm_pkg::IQRM_RUN: begin
          // the pair on the wire is allowed to finish before the converters stop
          if (!power_bit && !busy_q) begin
            state_q <= iqrm_pkg::IQRM_SLEEP;
          end
        end
        default: begin
          state_q <= iqrm_pkg::IQRM_SLEEP;
        end
      endcase
    end
  end

  // converter power and input shorting pins
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      adc_power_on_out <= 1'b0;
      input_short_out <= 1'b0;
    end else begin
      adc_power_on_out <= (state_q != iqrm_pkg::IQRM_SLEEP);
      input_short_out <= (state_q == iqrm_pkg::IQRM_CAL);
    end
  end

  // ****************************************************************
  // offset averaging
  // ****************************************************************
  assign tot_i = 19'(sum_i_q + widen(adc_i_word_in));
  assign tot_q = 19'(sum_q_q + widen(adc_q_word_in));
  assign cal_done = (state_q == iqrm_pkg::IQRM_CAL) && power_bit && sample_tick &&
                    (cal_cnt_q == iqrm_pkg::CAL_LAST);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cal_cnt_q <= 4'h0;
      sum_i_q <= 19'h00000;
      sum_q_q <= 19'h00000;
    end else if (state_q != iqrm_pkg::IQRM_CAL) begin
      cal_cnt_q <= 4'h0;
      sum_i_q <= 19'h00000;
      sum_q_q <= 19'h00000;
    end else if (sample_tick) begin
      cal_cnt_q <= 4'(cal_cnt_q + 4'h1);
      sum_i_q <= tot_i;
      sum_q_q <= tot_q;
    end
  end

  // the average is divided by sixteen; only the low ten bits fit the offset word,
  // so an offset beyond its range wraps instead of saturating
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      off_i_q <= iqrm_pkg::OFFSET_RESET;
      off_q_q <= iqrm_pkg::OFFSET_RESET;
    end else if (word_valid && word_addr == iqrm_pkg::ADDR_RESET) begin
      off_i_q <= iqrm_pkg::OFFSET_RESET;
      off_q_q <= iqrm_pkg::OFFSET_RESET;
    end else if (cal_done) begin
      off_i_q <= tot_i[13:4];
      off_q_q <= tot_q[13:4];
    end else if (word_valid && word_addr == iqrm_pkg::ADDR_I_OFFSET) begin
      off_i_q <= word_data;
    end else if (word_valid && word_addr == iqrm_pkg::ADDR_Q_OFFSET) begin
      off_q_q <= word_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      i_offset_out <= iqrm_pkg::OFFSET_RESET;
      q_offset_out <= iqrm_pkg::OFFSET_RESET;
    end else begin
      i_offset_out <= off_i_q;
      q_offset_out <= off_q_q;
    end
  end

  // ****************************************************************
  // iq word serializer
  // ****************************************************************
  // i word then q word, each fifteen sample bits and a flag (1 = i)
  assign pair_word = {apply_offset(adc_i_word_in, off_i_q), 1'b1,
                      apply_offset(adc_q_word_in, off_q_q), 1'b0};
  // no new pair once power is dropped; a tick while busy cannot occur at either rate
  assign start_pair = sample_tick && (state_q == iqrm_pkg::IQRM_RUN) && power_bit && !busy_q;

  // two clocks per bit, 64 clocks per pair, so the fast rate exactly fills the line
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      shift_q <= 32'h00000000;
      bit_idx_q <= 5'h00;
      phase_q <= 1'b0;
      busy_q <= 1'b0;
      rx_clk_out <= 1'b0;
      rx_data_out <= 1'b0;
      rx_frame_out <= 1'b0;
    end else if (start_pair) begin
      shift_q <= pair_word;
      bit_idx_q <= 5'h00;
      phase_q <= 1'b0;
      busy_q <= 1'b1;
      rx_clk_out <= 1'b1;
      rx_data_out <= pair_word[31];
      rx_frame_out <= 1'b1;
    end else if (busy_q && !phase_q) begin
      phase_q <= 1'b1;
      rx_clk_out <= 1'b0;
      if (bit_idx_q == iqrm_pkg::PAIR_LAST_BIT) begin
        busy_q <= 1'b0;
        rx_frame_out <= 1'b0;
      end
    end else if (busy_q) begin
      phase_q <= 1'b0;
      rx_clk_out <= 1'b1;
      shift_q <= {shift_q[30:0], 1'b0};
      bit_idx_q <= 5'(bit_idx_q + 5'h01);
      rx_data_out <= shift_q[30];
      rx_frame_out <= (5'(bit_idx_q + 5'h01) == iqrm_pkg::Q_FIRST_BIT);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  logic [7:0] gap_q;
  logic seen_q;
  logic rate_chg_q;
  logic [4:0] cal_ticks_q;

  // cycles since the previous sample tick, ignoring periods where the rate moved
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || state_q == iqrm_pkg::IQRM_SLEEP) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
      rate_chg_q <= 1'b0;
    end else if (sample_tick) begin
      gap_q <= 8'h00;
      seen_q <= 1'b1;
      rate_chg_q <= 1'b0;
    end else begin
      gap_q <= 8'(gap_q + 8'h01);
      if (cmd_q[iqrm_pkg::SAMPLE_RATE_SEL_BIT] != $past(cmd_q[iqrm_pkg::SAMPLE_RATE_SEL_BIT])) begin
        rate_chg_q <= 1'b1;
      end
    end
  end

  // ticks seen in the current calibration pass
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || state_q == iqrm_pkg::IQRM_SLEEP) begin
      cal_ticks_q <= 5'h00;
    end else if (state_q == iqrm_pkg::IQRM_CAL && sample_tick) begin
      cal_ticks_q <= 5'(cal_ticks_q + 5'h01);
    end else if (state_q != iqrm_pkg::IQRM_CAL && $past(state_q) != iqrm_pkg::IQRM_CAL) begin
      cal_ticks_q <= 5'h00;
    end
  end

  sequence s_frame_pair;
    rx_frame_out [*2] ##1 !rx_frame_out [*8] ##23 rx_frame_out [*2];
  endsequence

  sequence s_pair_busy;
    busy_q ##62 busy_q ##1 !busy_q;
  endsequence

  // a rate change landing on the tick cycle itself shortens that period, so it is skipped too
  a_slow_rate: assert property (sample_tick && seen_q && !rate_chg_q && $stable(cmd_q[0]) && !cmd_q[0]
      |-> gap_q == 8'd127)
    else $error("slow rate tick spacing wrong");
  a_fast_rate: assert property (sample_tick && seen_q && !rate_chg_q && $stable(cmd_q[0]) && cmd_q[0]
      |-> gap_q == 8'd63)
    else $error("fast rate tick spacing wrong");
  a_filter_tick_period: assert property (filter_tick_out |=> !filter_tick_out [*7] ##1 filter_tick_out)
    else $error("filter tick not every eight clocks");
  a_mode_pins_follow: assert property (##1 fir_response_sel_out == $past(cmd_q[1]) &&
      input_pair_sel_out == $past(cmd_q[2]))
    else $error("filter or input select pin mismatch");
  a_dac_power_follow: assert property (##1 narrow_trim_dac_b_power_out == $past(cmd_q[5]) &&
      narrow_trim_dac_a_power_out == $past(cmd_q[6]) && wide_trim_dac_power_out == $past(cmd_q[7]))
    else $error("dac power pin mismatch");
  a_tristate_release: assert property (cmd_q[8] |=> !rx_oe_out)
    else $error("serial outputs driven while tristated");
  a_sleep_waits_pair: assert property (state_q == iqrm_pkg::IQRM_RUN && busy_q |=> state_q != iqrm_pkg::IQRM_SLEEP)
    else $error("sleep entered during a pair");
  a_sleep_when_idle: assert property (state_q == iqrm_pkg::IQRM_RUN && !power_bit && !busy_q
      |=> state_q == iqrm_pkg::IQRM_SLEEP ##1 !adc_power_on_out)
    else $error("sleep not entered after pair");
  a_auto_cal_wake: assert property (state_q == iqrm_pkg::IQRM_SLEEP && power_bit && !cmd_q[3]
      |=> state_q == iqrm_pkg::IQRM_CAL ##1 input_short_out)
    else $error("auto calibration not started on wake");
  a_user_keeps_offset: assert property (state_q == iqrm_pkg::IQRM_SLEEP && power_bit && cmd_q[3] && !word_valid
      |=> state_q == iqrm_pkg::IQRM_RUN && $stable(off_i_q) && $stable(off_q_q))
    else $error("user mode wake disturbed offsets");
  a_cal_sixteen: assert property (state_q == iqrm_pkg::IQRM_RUN && $past(state_q) == iqrm_pkg::IQRM_CAL
      |-> cal_ticks_q == 5'd16)
    else $error("calibration did not average sixteen samples");
  a_pair_frames: assert property (start_pair |=> s_frame_pair)
    else $error("frame pulses misplaced in pair");
  a_pair_length: assert property (start_pair |=> s_pair_busy)
    else $error("pair not 32 bits long");
  a_offset_applied: assert property (start_pair |=> rx_data_out == $past(apply_offset(adc_i_word_in, off_i_q)) >> 14)
    else $error("first bit not offset-corrected msb");
  a_command_load: assert property (word_valid && word_addr == 4'h2 |=> cmd_q == ($past(word_data) & 10'h1ff))
    else $error("command word not loaded");

endmodule : iqrm_mode_ctrl

/* File: dv/iqrm_dsp_model.sv */
// dsp side model: collects serial iq words from the receive port
`timescale 1ns/1ps
module iqrm_dsp_model (
  input wire logic clk_sys_in,
  input wire logic rx_clk_in,
  input wire logic rx_frame_in,
  input wire logic rx_data_in,
  input wire logic rx_oe_in,
  output logic [15:0] i_word_out,
  output logic [15:0] q_word_out,
  output logic [7:0] pair_cnt_out
);
  logic [15:0] sr;
  logic [4:0] n;
  initial begin
    i_word_out = 16'h0000;
    q_word_out = 16'h0000;
    pair_cnt_out = 8'h00;
    n = 5'h00;
  end
  // one bit per high phase of the serial clock; ignored while released
  always @(posedge clk_sys_in) begin
    if (rx_oe_in && rx_clk_in) begin
      if (rx_frame_in) begin
        n = 5'h01;
        sr = {15'h0000, rx_data_in};
      end else begin
        n = n + 5'h01;
        sr = {sr[14:0], rx_data_in};
      end
      // sixteen bits close a word; the lsb flag sorts i from q
      if (n == 5'h10) begin
        if (sr[0]) begin
          i_word_out <= sr;
        end else begin
          q_word_out <= sr;
          pair_cnt_out <= pair_cnt_out + 8'h01;
        end
      end
    end
  end
endmodule : iqrm_dsp_model

/* File: dv/tb.sv */
// testbench for the receive mode control block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, lclk = 1'b0, lsel = 1'b0, ldat = 1'b0;
  logic [14:0] adc_i = 15'h0123, adc_q = 15'h7ffe;
  logic ftick, fir, pair, shrt, pwr, dac_b, dac_a, dac_w, rclk, rfrm, rdat, roe;
  logic [9:0] ioff, qoff;
  logic [15:0] iw, qw;
  logic [7:0] pc;
  int miscompares = 0, cmp_count = 0, c, n;
  iqrm_mode_ctrl i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .load_clk_in(lclk), .load_sel_in(lsel),
    .load_data_in(ldat), .adc_i_word_in(adc_i), .adc_q_word_in(adc_q), .filter_tick_out(ftick),
    .fir_response_sel_out(fir), .input_pair_sel_out(pair), .input_short_out(shrt), .adc_power_on_out(pwr),
    .narrow_trim_dac_b_power_out(dac_b), .narrow_trim_dac_a_power_out(dac_a), .wide_trim_dac_power_out(dac_w),
    .rx_clk_out(rclk), .rx_frame_out(rfrm), .rx_data_out(rdat), .rx_oe_out(roe), .i_offset_out(ioff),
    .q_offset_out(qoff));
  iqrm_dsp_model i_dsp (.clk_sys_in(clk), .rx_clk_in(rclk), .rx_frame_in(rfrm), .rx_data_in(rdat),
    .rx_oe_in(roe), .i_word_out(iw), .q_word_out(qw), .pair_cnt_out(pc));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // one load word msb first; the slow serial clock gives the synchronisers room
  task automatic load(input logic [3:0] a, input logic [9:0] d);
    logic [15:0] w;
    w = {a, 2'b00, d};
    lsel = 1'b1;
    for (int b = 15; b >= 0; b--) begin
      ldat = w[b];
      lclk = 1'b0;
      repeat (4) @(negedge clk);
      lclk = 1'b1;
      repeat (4) @(negedge clk);
    end
    lclk = 1'b0;
    repeat (4) @(negedge clk);
    lsel = 1'b0;
    repeat (6) @(negedge clk);
  endtask : load
  // cycles until the next complete pair; a stuck stream ends the run
  task automatic wait_pair(output int k);
    logic [7:0] p;
    p = pc;
    k = 0;
    while (pc === p && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_pair
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(pwr, 1'b0);
    chk(roe, 1'b1);
    n = 0;
    repeat (80) begin
      @(negedge clk);
      n += ftick;
    end
    chk(16'(n), 16'h000a);
    // user offsets, then fast rate with every mode bit but aux dac two and tristate, and the spare set
    load(4'h5, 10'h004);
    load(4'h6, 10'h3ff);
    chk(ioff, 10'h004);
    load(4'h2, 10'h2bf);
    chk({fir, pair, dac_b, dac_a, dac_w, pwr}, 6'h3b);
    chk(shrt, 1'b0);
    wait_pair(c);
    wait_pair(c);
    chk(16'(c), 16'h0040);
    chk(iw, 16'h023f);
    chk(qw, 16'hfffe);
    // slow rate with the other selections flipped
    load(4'h2, 10'h058);
    chk({fir, pair, dac_b, dac_a, dac_w}, 5'h02);
    wait_pair(c);
    wait_pair(c);
    chk(16'(c), 16'h0080);
    // sleep stops the stream
    load(4'h2, 10'h008);
    repeat (150) @(negedge clk);
    chk(pwr, 1'b0);
    n = pc;
    repeat (300) @(negedge clk);
    chk(pc, 8'(n));
    // auto wake measures offsets and cancels them
    load(4'h2, 10'h010);
    chk(shrt, 1'b1);
    chk(pwr, 1'b1);
    wait_pair(c);
    chk({6'h00, ioff}, 16'h0123);
    chk({6'h00, qoff}, 16'h03fe);
    chk(iw, 16'h0001);
    chk(qw, 16'h0000);
    load(4'h2, 10'h110);
    chk(roe, 1'b0);
    load(4'h1, 10'h000);
    // a pair on the wire finishes before the converters sleep, so allow one pair length
    repeat (70) @(negedge clk);
    chk({roe, pwr, ioff}, 12'h800);
    finish_test();
  end
endmodule : tb
